// File: src/bfs_sequencer.sv
// Purpose: two-channel beacon flash sequencer with activation and test
// Assumes: all pins but clock and reset asynchronous, synchronised here; one 200 MHz clock
// Notes:   run length after activation is a parameter; brightness is a level

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - alternating pattern: channel one half second, then two
// - second alternating step: one dark, two lit
// - fast pattern: eight 50 ms wig-wag slots first
// - then both lit, both dark, both lit
// - 250 ms dark closes twelve-slot cycle
// - field select input picks the pattern
// - any activation source starts flashing
// - on-demand command runs as pedestrian request
// - on request while idle and not activated, test knockdown, battery, outage; report
// - bright by day, dim by night
module bfs_sequencer
  import bfs_pkg::*;
#(
  // slot lengths open to override so short runs reach every slot
  parameter int unsigned RUN_CYCLES       = 32'hA,
  parameter int unsigned HALF_SLOT_CYCLES = HALF_SEC_CYC,
  parameter int unsigned FAST_SLOT_CYCLES = FAST_SLOT_CYC,
  parameter int unsigned LONG_SLOT_CYCLES = LONG_DARK_CYC
)
(
  input  wire logic I_REF_CLK,
  input  wire logic I_SYS_RST,
  input  wire logic i_pushbutton,
  input  wire logic i_microwave,
  input  wire logic i_ped_pad,
  input  wire logic i_bollard,
  input  wire logic i_ondemand,
  input  wire logic i_pattern_sel,
  input  wire logic i_daylight,
  input  wire logic i_test_req,
  input  wire logic i_link_ok,
  input  wire logic i_battery_ok,
  input  wire logic i_ch1_sense,
  input  wire logic i_ch2_sense,
  output logic      o_ch1,
  output logic      o_ch2,
  output logic      o_high_bright,
  output logic      o_active,
  output logic      o_activation,
  output logic      o_test_done,
  output logic      o_knockdown,
  output logic      o_battery_low,
  output logic      o_outage
);

  localparam int unsigned NSYNC = 12;

  typedef struct packed
  {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic             act_d;
    bfs_state_t       state;
    bfs_pattern_t     pat;
    logic [3:0]       slot;
    logic [31:0]      cycles_left;
    logic             ch1;
    logic             ch2;
    logic             bright;
    logic             activation;
    logic             test_done;
    logic             knockdown;
    logic             battery_low;
    logic             outage;
    logic             test_d;
  } bfs_seq_t;

  bfs_seq_t st;
  bfs_seq_t next_st;
  logic     tmr_load;
  logic     tmr_tick;
  logic [31:0] tmr_len;

  // ==========================================================================
  // slot tables
  // ==========================================================================
  function automatic logic [31:0] slot_len(bfs_pattern_t p, logic [3:0] s);
    if (p == PAT_ALTERNATING)
    begin
      return HALF_SLOT_CYCLES;
    end
    else if (s == WWS_LAST_SLOT)
    begin
      return LONG_SLOT_CYCLES;
    end
    return FAST_SLOT_CYCLES;
  endfunction : slot_len

  function automatic logic [1:0] slot_lamps(bfs_pattern_t p, logic [3:0] s);
    if (p == PAT_ALTERNATING)
    begin
      return {ALT_CH2_MAP[s[0]], ALT_CH1_MAP[s[0]]};
    end
    return {WWS_CH2_MAP[s], WWS_CH1_MAP[s]};
  endfunction : slot_lamps

  function automatic logic [3:0] last_slot(bfs_pattern_t p);
    return (p == PAT_ALTERNATING) ? ALT_LAST_SLOT : WWS_LAST_SLOT;
  endfunction : last_slot

  // ==========================================================================
  // next state
  // ==========================================================================
  logic [NSYNC-1:0] pins;
  assign pins = {i_ch2_sense, i_ch1_sense, i_battery_ok, i_link_ok, i_test_req,
                 i_daylight, i_pattern_sel, i_ondemand, i_bollard, i_ped_pad,
                 i_microwave, i_pushbutton};

  always_comb
  begin
    logic         act;
    logic         act_rise;
    logic         test_rise;
    bfs_pattern_t sel;
    act       = |st.s2[4:0];
    act_rise  = act && !st.act_d;
    test_rise = st.s2[7] && !st.test_d;
    sel       = st.s2[5] ? PAT_WIGWAG_SIM : PAT_ALTERNATING;
    next_st   = st;
    tmr_load  = 1'b0;
    next_st.s1     = pins;
    next_st.s2     = st.s1;
    next_st.act_d  = act;
    next_st.test_d = st.s2[7];
    next_st.bright = st.s2[6];
    next_st.activation = act_rise;
    next_st.test_done  = 1'b0;
    unique case (st.state)
      ST_IDLE:
      begin
        next_st.ch1 = 1'b0;
        next_st.ch2 = 1'b0;
        if (act)
        begin
          // restart at slot zero with the selection of this moment
          next_st.state       = ST_RUN;
          next_st.pat         = sel;
          next_st.slot        = FIRST_SLOT;
          next_st.cycles_left = RUN_CYCLES;
          tmr_load            = 1'b1;
          {next_st.ch2, next_st.ch1} = slot_lamps(sel, FIRST_SLOT);
        end
        else if (test_rise)
        begin
          // lamps dark before the test so the sense lines read an honest off
          next_st.state = ST_TEST;
        end
      end
      ST_RUN:
      begin
        if (act)
        begin
          next_st.cycles_left = RUN_CYCLES;
        end
        if (tmr_tick)
        begin
          tmr_load = 1'b1;
          if (st.slot == last_slot(st.pat))
          begin
            next_st.slot = FIRST_SLOT;
            next_st.pat  = sel;
            if (!act && st.cycles_left <= CNT_ONE)
            begin
              next_st.state = ST_IDLE;
              next_st.ch1   = 1'b0;
              next_st.ch2   = 1'b0;
              tmr_load      = 1'b0;
            end
            else
            begin
              if (!act)
              begin
                next_st.cycles_left = st.cycles_left - CNT_ONE;
              end
              {next_st.ch2, next_st.ch1} = slot_lamps(sel, FIRST_SLOT);
            end
          end
          else
          begin
            next_st.slot = st.slot + 4'h1;
            {next_st.ch2, next_st.ch1} = slot_lamps(st.pat, st.slot + 4'h1);
          end
        end
      end
      ST_TEST:
      begin
        // sense pins report lamp current with both channels dark here
        next_st.knockdown   = !st.s2[8];
        next_st.battery_low = !st.s2[9];
        next_st.outage      = st.s2[10] || st.s2[11];
        next_st.test_done   = 1'b1;
        next_st.state       = ST_IDLE;
      end
      default:
      begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  assign tmr_len = tmr_load ? slot_len(next_st.pat, next_st.slot) : CNT_ZERO;

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // slot timer
  // ==========================================================================
  bfs_slot_timer u_timer
  (
    .i_clk  (I_REF_CLK),
    .i_rst  (I_SYS_RST),
    .i_load (tmr_load),
    .i_len  (tmr_len),
    .o_tick (tmr_tick)
  );

  assign o_ch1         = st.ch1;
  assign o_ch2         = st.ch2;
  assign o_high_bright = st.bright;
  assign o_active      = (st.state == ST_RUN);
  assign o_activation  = st.activation;
  assign o_test_done   = st.test_done;
  assign o_knockdown   = st.knockdown;
  assign o_battery_low = st.battery_low;
  assign o_outage      = st.outage;

endmodule : bfs_sequencer

`default_nettype wire

// File: pkg/bfs_pkg.sv
// Purpose: shared constants and types for the beacon flash sequencer
// Assumes: 200 MHz reference clock
// Notes:   times held in microseconds, cycle counts derived from them

package bfs_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned HALF_SEC_US      = 500000;
  localparam int unsigned FAST_SLOT_US     = 50000;
  localparam int unsigned LONG_DARK_US     = 250000;
  localparam int unsigned HALF_SEC_CYC     = HALF_SEC_US * CLK_MHZ;
  localparam int unsigned FAST_SLOT_CYC    = FAST_SLOT_US * CLK_MHZ;
  localparam int unsigned LONG_DARK_CYC    = LONG_DARK_US * CLK_MHZ;

  // ==========================================================================
  // pattern tables
  // ==========================================================================
  localparam int unsigned SLOT_W           = 4;
  localparam logic [3:0]  ALT_LAST_SLOT    = 4'h1;
  localparam logic [3:0]  WWS_LAST_SLOT    = 4'hB;
  localparam logic [3:0]  FIRST_SLOT       = 4'h0;
  // one bit per slot, bit 0 = slot 0
  localparam logic [11:0] WWS_CH1_MAP      = 12'h511;
  localparam logic [11:0] WWS_CH2_MAP      = 12'h544;
  localparam logic [1:0]  ALT_CH1_MAP      = 2'h1;
  localparam logic [1:0]  ALT_CH2_MAP      = 2'h2;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic
  {
    PAT_ALTERNATING,
    PAT_WIGWAG_SIM
  } bfs_pattern_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_RUN,
    ST_TEST
  } bfs_state_t;

  localparam logic [31:0] CNT_ZERO         = 32'h0;
  localparam logic [31:0] CNT_ONE          = 32'h1;

endpackage : bfs_pkg

// File: src/bfs_slot_timer.sv
// Purpose: slot duration counter, one-cycle tick when a slot expires
// Assumes: length sampled while load is high
// Notes:   loading restarts the slot

`timescale 1ns/1ps
`default_nettype none

module bfs_slot_timer
  import bfs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic [31:0] i_len,
  output logic             o_tick
);

  typedef struct packed
  {
    logic [31:0] cnt;
  } bfs_tmr_t;

  bfs_tmr_t st;
  bfs_tmr_t next_st;

  // ==========================================================================
  // counter
  // ==========================================================================
  always_comb
  begin
    next_st = st;
    if (i_load)
    begin
      // tick on the last cycle, so a slot lasts exactly its length
      next_st.cnt = i_len;
    end
    else if (st.cnt != CNT_ZERO)
    begin
      next_st.cnt = st.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_tick = !i_load && (st.cnt == CNT_ONE);

endmodule : bfs_slot_timer

`default_nettype wire

// File: verif/bfs_seq_props.sv
// Purpose: port checks for the flash sequencer
// Assumes: one clock, sync reset
// Notes:   slots assumed longer than eight cycles
`timescale 1ns/1ps
`default_nettype none
module bfs_seq_props
(
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_pushbutton,
  input wire logic i_microwave,
  input wire logic i_ped_pad,
  input wire logic i_bollard,
  input wire logic i_ondemand,
  input wire logic i_daylight,
  input wire logic o_ch1,
  input wire logic o_ch2,
  input wire logic o_high_bright,
  input wire logic o_active,
  input wire logic o_activation,
  input wire logic o_test_done
);
  // ==========
  // checks
  wire logic any_req;
  assign any_req = i_pushbutton | i_microwave | i_ped_pad | i_bollard | i_ondemand;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  chk_idle_dark: assert property (!o_active |-> !o_ch1 && !o_ch2)
    else $error("lamp lit while idle");
  chk_first_slot: assert property ($rose(o_active) |-> o_ch1 && !o_ch2)
    else $error("run opened off slot zero");
  chk_req_start: assert property ($rose(any_req) && !o_active |-> ##[1:5] o_active)
    else $error("request gave no run");
  chk_req_pulse: assert property ($rose(any_req) |-> ##[1:5] o_activation)
    else $error("request not reported");
  chk_act_pulse: assert property (o_activation |=> !o_activation)
    else $error("activation pulse too long");
  chk_test_pulse: assert property (o_test_done |=> !o_test_done)
    else $error("test done too long");
  chk_day_bright: assert property (i_daylight [*5] |-> o_high_bright)
    else $error("dim by day");
  chk_night_dim: assert property (!i_daylight [*5] |-> !o_high_bright)
    else $error("bright by night");
  // every slot outlasts eight cycles, shortened bench slots included
  chk_slot_hold: assert property
    ($changed({o_ch1, o_ch2}) && o_active
      |=> (!o_active || $stable({o_ch1, o_ch2})) [*8])
    else $error("slot cut short");
endmodule : bfs_seq_props
bind bfs_sequencer bfs_seq_props bfs_seq_props_i (.*);
`default_nettype wire

// File: verif/bfs_lamp_model.sv
// Purpose: lamp bar stand-in with fault sense
// Assumes: sense high marks a failed bar
// Notes:   a fault shows lit or dark
`timescale 1ns/1ps
`default_nettype none
module bfs_lamp_model
(
  input  wire logic i_clk,
  input  wire logic i_fault1,
  input  wire logic i_fault2,
  output logic      o_sense1,
  output logic      o_sense2
);
  // ==========
  // sense
  always_ff @(posedge i_clk)
  begin
    o_sense1 <= i_fault1;
    o_sense2 <= i_fault2;
  end
endmodule : bfs_lamp_model
`default_nettype wire

// File: verif/bfs_sequencer_tb.sv
// Purpose: directed bench for the flash sequencer
// Assumes: RUN_CYCLES 1
// Notes:   slots shortened by parameter so whole cycles fit
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer_tb;
  // ==========
  // set-up
  logic       clk;
  logic       rst;
  logic [4:0] req;
  logic       sel, day, treq, link, batt, f1, f2, seen_a, seen_t;
  wire logic  s1, s2, ch1, ch2, hb, act, apul, tdone, kd, blow, outg;
  int         n_errors, checks, cyc;
  // slots scaled down, keeping the ten to one to five ratio
  localparam int          half_cyc = 32'h64;
  localparam int          fast_cyc = 32'hA;
  localparam int          long_cyc = 32'h32;
  localparam logic [11:0] ww_ch1   = 12'h511;
  localparam logic [11:0] ww_ch2   = 12'h544;

  bfs_sequencer #(.RUN_CYCLES(1), .HALF_SLOT_CYCLES(half_cyc), .FAST_SLOT_CYCLES(fast_cyc),
                  .LONG_SLOT_CYCLES(long_cyc)) bfs_sequencer_i
  (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .i_pushbutton(req[0]), .i_microwave(req[1]),
    .i_ped_pad(req[2]), .i_bollard(req[3]), .i_ondemand(req[4]), .i_pattern_sel(sel),
    .i_daylight(day), .i_test_req(treq), .i_link_ok(link), .i_battery_ok(batt),
    .i_ch1_sense(s1), .i_ch2_sense(s2), .o_ch1(ch1), .o_ch2(ch2), .o_high_bright(hb),
    .o_active(act), .o_activation(apul), .o_test_done(tdone), .o_knockdown(kd),
    .o_battery_low(blow), .o_outage(outg)
  );
  bfs_lamp_model bfs_lamp_model_i
  (
    .i_clk(clk), .i_fault1(f1), .i_fault2(f2), .o_sense1(s1), .o_sense2(s2)
  );

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ==========
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // pulses are caught over the whole wait, cleared by reset
  task automatic run(input int n);
    repeat (n)
    begin
      tick(1);
      seen_a |= apul;
      seen_t |= tdone;
    end
  endtask : run

  // lamps three cycles into each slot of one whole cycle
  task automatic walk(input logic p);
    logic [2:0] want;
    for (int k = 0; k < (p ? 12 : 2); k++)
    begin
      want = p ? {ww_ch1[k], ww_ch2[k], 1'h1} : {k == 0, k == 1, 1'h1};
      cmp({ch1, ch2, act}, want);
      run(p ? ((k == 11) ? long_cyc : fast_cyc) : half_cyc);
    end
  endtask : walk

  task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %0t got %b want %b", $time, got, exp);
    end
  endtask : cmp

  // extra cycles flush the input synchronisers
  task automatic do_reset;
    rst = 1'h1;
    req = 5'h00;
    treq = 1'h0;
    {seen_a, seen_t} = 2'h0;
    tick(10);
    rst = 1'h0;
    tick(3);
  endtask : do_reset

  task automatic final_report;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ==========
  // tests
  initial
  begin
    {sel, day, f1, f2} = 4'h0;
    {link, batt} = 2'h3;
    do_reset();
    cmp({ch1, ch2, act}, 3'h0);
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 5; s++)
      begin
        do_reset();
        sel = p[0];
        req[s] = 1'h1;
        run(6);
        cmp({ch1, ch2, act}, 3'h5);
        cmp({seen_a, 2'h0}, 3'h4);
        sel = ~sel;
        treq = 1'h1;
        walk(p[0]);
        req[s] = 1'h0;
        walk(~p[0]);
        cmp({ch1, ch2, seen_t}, 3'h0);
        cmp({act, 2'h0}, 3'h0);
      end
    day = 1'h1;
    tick(5);
    cmp({hb, 2'h0}, 3'h4);
    day = 1'h0;
    tick(5);
    cmp({hb, 2'h0}, 3'h0);
    do_reset();
    {link, batt, f1} = 3'h1;
    treq = 1'h1;
    run(2000);
    cmp({seen_t, kd, blow}, 3'h7);
    cmp({outg, act, seen_a}, 3'h4);
    {link, batt, f1, treq} = 4'hC;
    {seen_a, seen_t} = 2'h0;
    tick(1);
    treq = 1'h1;
    run(2000);
    cmp({seen_t, kd, blow}, 3'h4);
    cmp({outg, act, seen_a}, 3'h0);
    final_report();
  end
endmodule : bfs_sequencer_tb
`default_nettype wire
